// file: logic/bfs_breaker_failure_stage.sv
`include "bfs_cfg.svh"
module bfs_breaker_failure_stage #(
   parameter int NOUT        = 4,
   parameter int SW          = 2,
   parameter int TICK_CYC    = `BFS_TICK_CYCLES,
   parameter int FORCE_TICKS = `BFS_FORCE_TICKS
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // trip output control signals from the output matrix
   input  wire logic [NOUT-1:0]      trip_ctrl,
   input  wire logic                 stage_block,
   // settings
   input  wire logic                 auth_ok,
   input  wire logic                 set_wr,
   input  wire logic [SW-1:0]        set_sel,
   input  wire logic [15:0]          set_opt_ms,
   input  wire logic                 force_set,
   input  wire logic                 force_clr,
   input  wire logic                 force_start,
   input  wire logic                 force_trip,
   input  wire logic                 start_cnt_clr,
   input  wire logic                 trip_cnt_clr,
   // time stamp source
   input  wire logic [15:0]          now_date,
   input  wire logic [26:0]          now_msec,
   input  wire logic [2:0]           log_idx,
   // outputs
   output logic                      backup_trip,
   output bfs_pkg::bfs_status_t      stage_status,
   output logic [SW-1:0]             sup_sel,
   output logic                      force_on,
   output logic [15:0]               start_event_count,
   output logic [15:0]               trip_event_count,
   output logic [15:0]               log_date,
   output logic [26:0]               log_msec,
   output logic [7:0]                elapsed_delay_percent
);
   import bfs_pkg::*;
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int FW = $clog2(FORCE_TICKS + 1);

   bfs_state_t  st_q, st_d;
   logic [SW-1:0] sel_q;
   logic [15:0] opt_q, ms_q;
   logic [TW-1:0] pre_q;
   logic [FW-1:0] fto_q;
   logic        force_q, fs_q, ft_q, prim_q;
   logic [15:0] sc_q, tc_q;
   logic        log_wr_q;
   logic [7:0]  log_pct_q;

   // any function routed to the one output arm selected by sel_q
   wire prim     = trip_ctrl[sel_q];
   wire tick     = (pre_q == TW'(TICK_CYC - 1));
   wire expired  = (ms_q >= opt_q) && tick;
   wire start_ev = (st_q == BFS_IDLE) && prim && !stage_block;
   wire trip_ev  = (st_q == BFS_TIMING) && prim && expired;
   wire early_ev = (st_q == BFS_TIMING) && !prim;
   wire [31:0] pct_w = (opt_q == 16'h0000) ? 32'h00000064 :
                       ({16'h0000, ms_q} * 32'h00000064) / {16'h0000, opt_q};
   wire [7:0]  pct_sat = (pct_w > 32'h00000063) ? 8'h63 : pct_w[7:0];

   always_comb begin
      st_d = st_q;
      case (st_q)
         BFS_IDLE:    if (start_ev) st_d = BFS_TIMING;
         BFS_TIMING:  if (early_ev) st_d = BFS_IDLE;
                      else if (trip_ev) st_d = BFS_BACKUP;
         BFS_BACKUP:  if (!prim) st_d = BFS_WAITREL;
         BFS_WAITREL: st_d = BFS_IDLE;
         default:     st_d = BFS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= BFS_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || st_q != BFS_TIMING) begin
         pre_q <= '0;
         ms_q  <= 16'h0000;
      end else begin
         pre_q <= tick ? '0 : pre_q + TW'(1);
         if (tick && ms_q != 16'hFFFF) ms_q <= ms_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sel_q <= SW'(`BFS_SEL_RST);
         opt_q <= `BFS_OPT_RST;
      end else if (set_wr && auth_ok) begin
         sel_q <= set_sel;
         opt_q <= set_opt_ms;
      end
   end

   // free running ms tick, so the force timeout runs whether or not a fault is timed
   logic [TW-1:0] fpre_q;
   wire tick_free = (fpre_q == TW'(TICK_CYC - 1));
   always_ff @(posedge core_clk) begin
      if (sys_rst || tick_free) fpre_q <= '0;
      else fpre_q <= fpre_q + TW'(1);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         force_q <= 1'b0;
         fto_q   <= '0;
      end else if (force_set && auth_ok) begin
         force_q <= 1'b1;
         fto_q   <= '0;
      end else if (force_clr || (force_q && fto_q == FW'(FORCE_TICKS))) begin
         force_q <= 1'b0;
         fto_q   <= '0;
      end else if (force_q && tick_free) begin
         fto_q   <= fto_q + FW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || !force_q) begin
         fs_q <= 1'b0;
         ft_q <= 1'b0;
      end else begin
         fs_q <= force_start;
         ft_q <= force_trip;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sc_q <= 16'h0000;
         tc_q <= 16'h0000;
      end else begin
         if (start_ev) sc_q <= sc_q + 16'h0001;
         else if (start_cnt_clr) sc_q <= 16'h0000;
         if (trip_ev) tc_q <= tc_q + 16'h0001;
         else if (trip_cnt_clr) tc_q <= 16'h0000;
      end
   end

   // record on trip or early release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         log_wr_q  <= 1'b0;
         log_pct_q <= 8'h00;
      end else begin
         log_wr_q  <= trip_ev || early_ev;
         log_pct_q <= trip_ev ? `BFS_PCT_FULL : pct_sat;
      end
   end

   bfs_fault_log #(.DEPTH(`BFS_LOG_DEPTH), .IW(3)) u_log (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_en    (log_wr_q),
      .wr_date  (now_date),
      .wr_msec  (now_msec),
      .wr_pct   (log_pct_q),
      .rd_idx   (log_idx),
      .rd_date  (log_date),
      .rd_msec  (log_msec),
      .rd_pct   (elapsed_delay_percent)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         backup_trip       <= 1'b0;
         stage_status      <= BFS_ST_IDLE;
         sup_sel           <= SW'(`BFS_SEL_RST);
         force_on          <= 1'b0;
         start_event_count <= 16'h0000;
         trip_event_count  <= 16'h0000;
      end else begin
         backup_trip <= (st_d == BFS_BACKUP) || ft_q;
         if (stage_block) stage_status <= BFS_ST_BLOCKED;
         else if (st_d == BFS_BACKUP || ft_q) stage_status <= BFS_ST_TRIP;
         else if (st_d == BFS_TIMING || fs_q) stage_status <= BFS_ST_START;
         else stage_status <= BFS_ST_IDLE;
         sup_sel           <= sel_q;
         force_on          <= force_q;
         start_event_count <= sc_q;
         trip_event_count  <= tc_q;
      end
   end

   a_backup_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      st_q == BFS_BACKUP && prim |-> ##1 backup_trip)
      else $error("backup dropped while primary active");
   a_early_nobk: assert property (@(posedge core_clk) disable iff (sys_rst)
      early_ev |-> ##1 (st_q == BFS_IDLE) ##1 !backup_trip || $past(ft_q))
      else $error("backup after early release");
   // raw cycles spent timing, kept apart from the ms timer it checks
   logic [47:0] run_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst || st_q != BFS_TIMING) run_q <= 48'h000000000000;
      else run_q <= run_q + 48'h000000000001;
   end
   a_trip_backup: assert property (@(posedge core_clk) disable iff (sys_rst)
      trip_ev |-> ##1 backup_trip) else $error("backup not raised");
   a_no_early: assert property (@(posedge core_clk) disable iff (sys_rst)
      trip_ev |-> run_q >= 48'(opt_q) * 48'(TICK_CYC))
      else $error("trip before operate time");
   a_force_to: assert property (@(posedge core_clk) disable iff (sys_rst)
      force_q && fto_q == FW'(FORCE_TICKS) && !(force_set && auth_ok)
      |-> ##1 !force_q) else $error("force not cleared");
   a_force_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      !force_q |-> ##1 !fs_q && !ft_q) else $error("forced without flag");
   a_start_cnt: assert property (@(posedge core_clk) disable iff (sys_rst)
      start_ev |-> ##1 sc_q == $past(sc_q) + 16'h0001) else $error("start count");
   a_set_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
      !auth_ok |-> ##1 $stable(sel_q) && $stable(opt_q)) else $error("setting changed");
   a_log_full: assert property (@(posedge core_clk) disable iff (sys_rst)
      trip_ev |-> ##1 log_wr_q && log_pct_q == 8'h64) else $error("log percent");
endmodule

// file: shared/bfs_cfg.svh
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH
// time base for delays and the force timeout: 1 ms tick at 100 MHz
`define BFS_CLK_HZ        100000000
`define BFS_TICK_NS       1000000
`define BFS_TICK_CYCLES   (`BFS_TICK_NS / 10)
// force flag timeout, 5 minutes, in ms ticks
`define BFS_FORCE_MIN     5
`define BFS_FORCE_TICKS   (`BFS_FORCE_MIN * 60 * 1000)
// operate time reset value in ms ticks
`define BFS_OPT_RST       16'h00C8
`define BFS_SEL_RST       2'h0
`define BFS_LOG_DEPTH     8
`define BFS_PCT_FULL      8'h64
`endif

// file: shared/bfs_pkg.sv
package bfs_pkg;
   typedef enum logic [1:0] {
      BFS_IDLE    = 2'b00,
      BFS_TIMING  = 2'b01,
      BFS_BACKUP  = 2'b11,
      BFS_WAITREL = 2'b10
   } bfs_state_t;
   typedef enum logic [1:0] {
      BFS_ST_IDLE    = 2'h0,
      BFS_ST_BLOCKED = 2'h1,
      BFS_ST_START   = 2'h2,
      BFS_ST_TRIP    = 2'h3
   } bfs_status_t;
endpackage

// file: logic/bfs_fault_log.sv
`include "bfs_cfg.svh"
module bfs_fault_log #(
   parameter int DEPTH = `BFS_LOG_DEPTH,
   parameter int IW    = 3
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   // new record
   input  wire logic          wr_en,
   input  wire logic [15:0]   wr_date,
   input  wire logic [26:0]   wr_msec,
   input  wire logic [7:0]    wr_pct,
   // read side, index 0 is the latest
   input  wire logic [IW-1:0] rd_idx,
   output logic      [15:0]   rd_date,
   output logic      [26:0]   rd_msec,
   output logic      [7:0]    rd_pct
);
   logic [15:0]   date_q [DEPTH];
   logic [26:0]   msec_q [DEPTH];
   logic [7:0]    pct_q  [DEPTH];
   logic [IW-1:0] head_q;
   wire  [IW-1:0] rd_slot = head_q - rd_idx - IW'(1);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         head_q <= '0;
      end else if (wr_en) begin
         head_q <= head_q + IW'(1);
      end
   end
   for (genvar g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            date_q[g] <= 16'h0000;
            msec_q[g] <= 27'h0000000;
            pct_q[g]  <= 8'h00;
         end else if (wr_en && head_q == IW'(g)) begin
            date_q[g] <= wr_date;
            msec_q[g] <= wr_msec;
            pct_q[g]  <= wr_pct;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      rd_date <= date_q[rd_slot];
      rd_msec <= msec_q[rd_slot];
      rd_pct  <= pct_q[rd_slot];
   end
endmodule

// file: dv/bfs_relay_model.sv
module bfs_relay_model (
   // clock
   input  wire logic       core_clk,
   // fault command from the bench
   input  wire logic       fault,
   input  wire logic [1:0] line,
   // control signals of T1..T4, bit0 is T1
   output logic      [3:0] trip_ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   // coil drive lags the command by one cycle, as a real output stage would
   always_ff @(posedge core_clk) begin
      trip_ctrl <= fault ? (4'h1 << line) : 4'h0;
   end
endmodule

// file: dv/breaker_failure_backup_trip_test.sv
module breaker_failure_backup_trip_test
   import bfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 10;
   localparam int FT = 5;
   typedef struct {logic [1:0] sel; logic [1:0] line; int opt; int hold; logic exp;} bfs_row_t;
   // short operate times keep the run brief; hold is in ms ticks
   bfs_row_t rows [4] = '{'{2'h0, 2'h0, 5, 3, 1'h0}, '{2'h1, 2'h1, 5, 9, 1'h1},
                          '{2'h2, 2'h3, 3, 8, 1'h0}, '{2'h3, 2'h3, 4, 2, 1'h0}};
   logic core_clk = 0, sys_rst = 1, fault = 0, stage_block = 0, auth_ok = 0, set_wr = 0;
   logic force_set = 0, force_clr = 0, force_start = 0, force_trip = 0;
   logic start_cnt_clr = 0, trip_cnt_clr = 0, backup_trip, force_on;
   logic [1:0] line = 2'h0, set_sel = 2'h0, sup_sel;
   logic [2:0] log_idx = 3'h0;
   logic [3:0] trip_ctrl;
   logic [15:0] set_opt_ms = 16'h0000, now_date = 16'h0100, log_date;
   logic [15:0] start_event_count, trip_event_count;
   logic [26:0] now_msec = 27'h0001000, log_msec;
   logic [7:0] elapsed_delay_percent;
   bfs_status_t stage_status, exp_st;
   int n_fail = 0, checks_done = 0, nst = 0, ntr = 0;

   bfs_relay_model i_bfs_relay_model (.core_clk(core_clk), .fault(fault), .line(line),
      .trip_ctrl(trip_ctrl));
   bfs_breaker_failure_stage #(.TICK_CYC(TK), .FORCE_TICKS(FT)) i_bfs_breaker_failure_stage (
      .core_clk(core_clk), .sys_rst(sys_rst), .trip_ctrl(trip_ctrl), .stage_block(stage_block),
      .auth_ok(auth_ok), .set_wr(set_wr), .set_sel(set_sel), .set_opt_ms(set_opt_ms),
      .force_set(force_set), .force_clr(force_clr), .force_start(force_start),
      .force_trip(force_trip), .start_cnt_clr(start_cnt_clr), .trip_cnt_clr(trip_cnt_clr),
      .now_date(now_date), .now_msec(now_msec), .log_idx(log_idx), .backup_trip(backup_trip),
      .stage_status(stage_status), .sup_sel(sup_sel), .force_on(force_on),
      .start_event_count(start_event_count), .trip_event_count(trip_event_count),
      .log_date(log_date), .log_msec(log_msec), .elapsed_delay_percent(elapsed_delay_percent));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic setup(input logic a, input logic [1:0] s, input int o);
      auth_ok = a;
      set_sel = s;
      set_opt_ms = o[15:0];
      set_wr = 1;
      cyc(1);
      set_wr = 0;
      cyc(1);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      cyc(20000);
      n_fail++;
      stop_test();
   end

   initial begin
      cyc(8);
      sys_rst = 0;
      cyc(1);
      chk("rst_backup", 0, backup_trip);
      chk("rst_status", BFS_ST_IDLE, stage_status);
      chk("rst_counts", 0, {start_event_count, trip_event_count});
      setup(0, 2'h2, 3);
      chk("sel_noauth", 0, sup_sel);
      foreach (rows[i]) begin
         setup(1, rows[i].sel, rows[i].opt);
         now_date = 16'h0100 + 16'(i);
         now_msec = 27'h0001000 + 27'(i);
         line = rows[i].line;
         fault = 1;
         if (rows[i].exp) begin
            cyc(rows[i].opt * TK - TK);
            chk("early_backup", 0, backup_trip);
            cyc((rows[i].hold - rows[i].opt + 1) * TK);
         end else begin
            cyc(rows[i].hold * TK);
         end
         exp_st = rows[i].exp ? BFS_ST_TRIP :
                  (rows[i].sel == rows[i].line ? BFS_ST_START : BFS_ST_IDLE);
         chk("backup", rows[i].exp, backup_trip);
         chk("status", exp_st, stage_status);
         chk("sup_sel", rows[i].sel, sup_sel);
         nst += (rows[i].sel == rows[i].line);
         ntr += rows[i].exp;
         fault = 0;
         cyc(3);
         chk("backup_rel", 0, backup_trip);
      end
      chk("start_cnt", nst, start_event_count);
      chk("trip_cnt", ntr, trip_event_count);
      cyc(1);
      // last row released after one whole ms of four
      chk("pct_early", 8'h19, elapsed_delay_percent);
      log_idx = 3'h1;
      cyc(2);
      chk("pct_trip", 8'h64, elapsed_delay_percent);
      chk("log_date", 16'h0101, log_date);
      chk("log_msec", 27'h0001001, log_msec);
      start_cnt_clr = 1;
      cyc(1);
      start_cnt_clr = 0;
      cyc(1);
      chk("start_clr", 0, start_event_count);
      chk("trip_kept", ntr, trip_event_count);
      trip_cnt_clr = 1;
      cyc(1);
      trip_cnt_clr = 0;
      cyc(1);
      chk("trip_clr", 0, trip_event_count);
      stage_block = 1;
      fault = 1;
      cyc(3 * TK);
      chk("blocked", BFS_ST_BLOCKED, stage_status);
      chk("blk_start", 0, start_event_count);
      fault = 0;
      // let the relay stage drop before unblocking, else a stale primary starts
      cyc(2);
      stage_block = 0;
      force_trip = 1;
      cyc(3);
      chk("force_noflag", BFS_ST_IDLE, stage_status);
      force_set = 1;
      cyc(1);
      force_set = 0;
      cyc(2);
      chk("force_on", 1, force_on);
      chk("force_trip", BFS_ST_TRIP, stage_status);
      chk("force_backup", 1, backup_trip);
      // timeout counted in ms ticks, two spare ticks for phase of the tick
      cyc((FT + 2) * TK);
      chk("force_timeout", 0, force_on);
      chk("force_bk_off", 0, backup_trip);
      force_trip = 0;
      stop_test();
   end
endmodule
